// ==== hdl/brd_decoder.sv ====
// Top of the boot remap address decoder: one registered routing stage.
// Assumes masters hold a request for one cycle; targets give their own data.
// Operation
// - Sixteen 256 Mbyte banks picked by address bits 31 to 28.
// - Banks one to six drive external selects zero to five in order.
// - Bank seven goes only to the DRAM controller and its chip select.
// - Bank zero holds internal memories, decoded further into 1 Mbyte regions.
// - Bank fifteen routes to the peripheral bridge.
// - Banks with no target answer with an abort.
// - SRAM is 64 Kbytes in four 16 Kbyte blocks behind one port.
// - SRAM sits at 0x300000; after remap it also appears at zero.
// - Wait bit adds one wait state on TCM accesses; software sets it.
// - Partition: all SRAM, all data TCM, or split instruction and data TCM.
// - SRAM open to all at 0x300000; at zero only for processor masters.
// - ROM always at 0x400000; at zero before remap if boot pin high.
// - Window zero to 0xFFFFF is the boot window chosen by captured pin.
// - Captured pin high maps ROM, low maps external select zero.
// - Processor fetches from zero after reset, seeing the boot memory.
// - ROM always answers at its own base address; SRAM and TCMs only when the partition enables them.
// - External boot starts the static controller in byte select 16-bit mode.
// - A per-master remap bit chooses boot memory or SRAM at zero, for the two processor masters only.
`timescale 1ns/10ps
module brd_decoder (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire brd_pkg::brd_req_s req_in,
  input wire logic boot_select_pin_in,
  input wire logic [brd_pkg::NUM_MASTERS-1:0] master_remap_bit_in,
  input wire logic tcm_wait_state_bit_in,
  input wire brd_pkg::brd_part_e part_in,
  output brd_pkg::brd_route_s route_out,
  output logic tcm_wait_out,
  output logic boot_from_rom_out,
  output logic smc_byte_select_out,
  output logic smc_bus16_out,
  output logic smc_cs_qualified_out
);
  import brd_pkg::*;

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic boot_sync1_reg;
  logic boot_sync2_reg;
  logic boot_captured_reg;
  logic boot_from_rom_reg;
  brd_route_s route_reg;
  brd_route_s route_next;
  logic tcm_wait_reg;
  logic smc_default_reg;
  wire rst_n = rst_sync2_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      boot_sync1_reg <= 1'b0;
      boot_sync2_reg <= 1'b0;
    end else begin
      boot_sync1_reg <= boot_select_pin_in;
      boot_sync2_reg <= boot_sync1_reg;
    end
  end

  // Boot pin latched once, three cycles after reset release
  logic [1:0] cap_cnt_reg;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt_reg <= 2'h0;
      boot_captured_reg <= 1'b0;
      boot_from_rom_reg <= 1'b0;
    end else if (!boot_captured_reg) begin
      cap_cnt_reg <= cap_cnt_reg + 2'h1;
      if (cap_cnt_reg == 2'h2) begin
        boot_captured_reg <= 1'b1;
        boot_from_rom_reg <= boot_sync2_reg;
      end
    end
  end

  wire req_ok = req_in.valid && boot_captured_reg;
  wire [3:0] bank = req_in.addr[ADDR_W-1:BANK_LSB];
  wire master_legal = req_in.master < MST_W'(NUM_MASTERS);
  wire remap_sel = master_legal ? master_remap_bit_in[req_in.master] : 1'b0;
  wire is_ext = (bank >= BANK_EXT_FIRST) && (bank <= BANK_EXT_LAST);
  wire [2:0] ext_idx = 3'(bank - BANK_EXT_FIRST);
  brd_tgt_e int_tgt;

  brd_internal_dec u_internal (
    .addr_in(req_in.addr),
    .master_in(req_in.master),
    .remap_in(remap_sel),
    .boot_rom_in(boot_from_rom_reg),
    .part_in(part_in),
    .target_out(int_tgt)
  );

  always_comb begin
    route_next = '0;
    route_next.valid = req_ok;
    route_next.master = req_in.master;
    route_next.offset = req_in.addr;
    route_next.target = BRD_TGT_ABORT;
    if (bank == BANK_INTERNAL) begin
      route_next.target = int_tgt;
    end else if (is_ext) begin
      route_next.target = BRD_TGT_EXT;
      route_next.ext_select = 6'h01 << ext_idx;
    end else if (bank == BANK_DRAM) begin
      route_next.target = BRD_TGT_DRAM;
      route_next.dram_select = 1'b1;
    end else if (bank == BANK_PERIPH) begin
      route_next.target = BRD_TGT_PERIPH;
    end
    // Boot window toward external flash drives select zero
    if (bank == BANK_INTERNAL && int_tgt == BRD_TGT_EXT) begin
      route_next.ext_select = 6'h01;
    end
    if (route_next.target == BRD_TGT_SRAM) begin
      route_next.offset = {16'h0000, req_in.addr[15:0]};
    end else if (route_next.target == BRD_TGT_INSTR_COUPLED_MEMORY ||
                 route_next.target == BRD_TGT_DATA_COUPLED_MEMORY) begin
      route_next.offset = {16'h0000, req_in.addr[15:0]};
    end
    route_next.abort = route_next.target == BRD_TGT_ABORT;
    if (!req_ok) begin
      route_next.ext_select = 6'h00;
      route_next.dram_select = 1'b0;
      route_next.abort = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      route_reg <= '0;
      tcm_wait_reg <= 1'b0;
      smc_default_reg <= 1'b0;
    end else begin
      route_reg <= route_next;
      tcm_wait_reg <= req_ok && tcm_wait_state_bit_in &&
                      (route_next.target == BRD_TGT_INSTR_COUPLED_MEMORY ||
                       route_next.target == BRD_TGT_DATA_COUPLED_MEMORY);
      smc_default_reg <= boot_captured_reg && !boot_from_rom_reg;
    end
  end

  assign route_out = route_reg;
  assign tcm_wait_out = tcm_wait_reg;
  assign boot_from_rom_out = boot_from_rom_reg;
  assign smc_byte_select_out = smc_default_reg;
  assign smc_bus16_out = smc_default_reg;
  assign smc_cs_qualified_out = smc_default_reg;

  property p_bank_route(logic [3:0] b, brd_tgt_e t);
    @(posedge core_clk_in) disable iff (!rst_n)
      (req_ok && bank == b) |=> (route_reg.valid && route_reg.target == t);
  endproperty

  dram_bank_route_a: assert property (p_bank_route(BANK_DRAM, BRD_TGT_DRAM))
    else $error("bank seven not routed to dram");
  periph_bank_route_a: assert property (p_bank_route(BANK_PERIPH, BRD_TGT_PERIPH))
    else $error("bank fifteen not routed to bridge");
  unused_bank_abort_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (req_ok && bank inside {4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE}) |=> route_reg.abort)
    else $error("unused bank did not abort");
  ext_select_order_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (req_ok && is_ext) |=> route_reg.ext_select == (6'h01 << $past(ext_idx)))
    else $error("external select out of order");
  rom_fixed_base_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (req_ok && bank == BANK_INTERNAL && req_in.addr[27:20] == REGION_ROM)
      |=> route_reg.target == BRD_TGT_ROM)
    else $error("rom missing at fixed base");
  sequence s_boot_rom_fetch;
    req_ok && bank == BANK_INTERNAL && req_in.addr[27:20] == REGION_BOOT &&
    !remap_sel && boot_from_rom_reg;
  endsequence
  boot_window_rom_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      s_boot_rom_fetch |=> route_reg.target == BRD_TGT_ROM)
    else $error("boot window not on rom");
  boot_window_ext_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (req_ok && bank == BANK_INTERNAL && req_in.addr[27:20] == REGION_BOOT &&
       !remap_sel && !boot_from_rom_reg) |=> route_reg.ext_select == 6'h01)
    else $error("boot window not on select zero");
  remap_cpu_only_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (req_ok && bank == BANK_INTERNAL && req_in.addr[27:20] == REGION_BOOT &&
       req_in.master > MST_CPU_DATA) |=> route_reg.target != BRD_TGT_SRAM)
    else $error("non processor master saw sram at zero");
  tcm_wait_state_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      (req_ok && tcm_wait_state_bit_in && route_next.target == BRD_TGT_DATA_COUPLED_MEMORY) |=> tcm_wait_out)
    else $error("tcm wait state missing");
  boot_capture_once_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
      boot_captured_reg |=> $stable(boot_from_rom_reg))
    else $error("boot level changed after capture");
endmodule : brd_decoder

// ==== hdl/brd_internal_dec.sv ====
// Second-level decoder for bank zero: boot window, SRAM partitions, ROM.
// Assumes purely combinational use from the top level, same clock domain.
`timescale 1ns/10ps
module brd_internal_dec (
  input wire logic [brd_pkg::ADDR_W-1:0] addr_in,
  input wire logic [brd_pkg::MST_W-1:0] master_in,
  input wire logic remap_in,
  input wire logic boot_rom_in,
  input wire brd_pkg::brd_part_e part_in,
  output brd_pkg::brd_tgt_e target_out
);
  import brd_pkg::*;

  wire [7:0] region = addr_in[REGION_LSB+7:REGION_LSB];
  wire [19:0] inner = addr_in[REGION_LSB-1:0];
  wire cpu_master = (master_in == MST_CPU_INSTR) || (master_in == MST_CPU_DATA);
  wire in_sram = inner < 20'(SRAM_BYTES);
  wire in_half = inner < 20'(SRAM_HALF_BYTES);
  wire boot_hit = region == REGION_BOOT;
  wire instr_coupled_memory_ok = (part_in == BRD_PART_SPLIT_TCM) && in_half;
  wire data_coupled_memory_ok = ((part_in == BRD_PART_ALL_DATA_COUPLED_MEMORY) && in_sram) ||
                 ((part_in == BRD_PART_SPLIT_TCM) && in_half);
  wire sram_ok = (part_in == BRD_PART_ALL_SRAM) && in_sram;
  wire remap_view = remap_in && cpu_master;
  brd_tgt_e boot_tgt;

  always_comb begin
    // Remap wins over boot select only for processor masters
    if (remap_view) begin
      boot_tgt = sram_ok ? BRD_TGT_SRAM : BRD_TGT_ABORT;
    end else if (boot_rom_in) begin
      boot_tgt = BRD_TGT_ROM;
    end else begin
      boot_tgt = BRD_TGT_EXT;
    end
  end

  always_comb begin
    target_out = BRD_TGT_ABORT;
    if (boot_hit) begin
      target_out = boot_tgt;
    end else if (region == REGION_INSTR_COUPLED_MEMORY) begin
      target_out = instr_coupled_memory_ok ? BRD_TGT_INSTR_COUPLED_MEMORY : BRD_TGT_ABORT;
    end else if (region == REGION_DATA_COUPLED_MEMORY) begin
      target_out = data_coupled_memory_ok ? BRD_TGT_DATA_COUPLED_MEMORY : BRD_TGT_ABORT;
    end else if (region == REGION_SRAM) begin
      target_out = sram_ok ? BRD_TGT_SRAM : BRD_TGT_ABORT;
    end else if (region == REGION_ROM) begin
      target_out = BRD_TGT_ROM;
    end
  end
endmodule : brd_internal_dec

// ==== inc/brd_pkg.sv ====
// Package for the boot remap address decoder: address map, targets, carriers.
// Assumes one system clock and a 32-bit address bus from each master.
package brd_pkg;
  localparam int ADDR_W = 32;
  localparam int BANK_LSB = 28;
  localparam int NUM_MASTERS = 12;
  localparam int MST_W = 4;
  localparam logic [3:0] BANK_INTERNAL = 4'h0;
  localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
  localparam logic [3:0] BANK_EXT_LAST = 4'h6;
  localparam logic [3:0] BANK_DRAM = 4'h7;
  localparam logic [3:0] BANK_PERIPH = 4'hF;
  localparam int REGION_LSB = 20;
  localparam logic [7:0] REGION_BOOT = 8'h00;
  localparam logic [7:0] REGION_INSTR_COUPLED_MEMORY = 8'h01;
  localparam logic [7:0] REGION_DATA_COUPLED_MEMORY = 8'h02;
  localparam logic [7:0] REGION_SRAM = 8'h03;
  localparam logic [7:0] REGION_ROM = 8'h04;
  localparam int SRAM_BYTES = 65536;
  localparam int SRAM_BLOCK_BYTES = 16384;
  localparam int SRAM_HALF_BYTES = 32768;
  localparam logic [3:0] MST_CPU_INSTR = 4'h0;
  localparam logic [3:0] MST_CPU_DATA = 4'h1;
  localparam logic [1:0] TCM_WAIT_CYCLES = 2'h1;

  typedef enum logic [1:0] {
    BRD_PART_ALL_SRAM = 2'b00,
    BRD_PART_ALL_DATA_COUPLED_MEMORY = 2'b01,
    BRD_PART_SPLIT_TCM = 2'b10
  } brd_part_e;

  typedef enum logic [3:0] {
    BRD_TGT_ABORT = 4'h0,
    BRD_TGT_EXT = 4'h1,
    BRD_TGT_DRAM = 4'h2,
    BRD_TGT_SRAM = 4'h3,
    BRD_TGT_ROM = 4'h4,
    BRD_TGT_PERIPH = 4'h5,
    BRD_TGT_INSTR_COUPLED_MEMORY = 4'h6,
    BRD_TGT_DATA_COUPLED_MEMORY = 4'h7
  } brd_tgt_e;

  typedef struct packed {
    logic valid;
    logic [MST_W-1:0] master;
    logic [ADDR_W-1:0] addr;
  } brd_req_s;

  typedef struct packed {
    logic valid;
    brd_tgt_e target;
    logic [5:0] ext_select;
    logic dram_select;
    logic abort;
    logic [ADDR_W-1:0] offset;
    logic [MST_W-1:0] master;
  } brd_route_s;
endpackage : brd_pkg

// ==== test/brd_decoder_tb.sv ====
// Self-checking bench for the boot remap address decoder.
// Assumes a registered route one cycle after each accepted request.
`timescale 1ns/10ps
module brd_decoder_tb;
  import brd_pkg::*;
  logic clk, rst_n, go, pin, wbit, pv, pw;
  logic [3:0] mst, pm;
  logic [31:0] adr, pa, seed;
  logic [11:0] rbits;
  brd_part_e part;
  brd_tgt_e pt;
  brd_req_s req;
  brd_route_s route;
  logic twait, brom, sbs, s16, scs;
  int err_total, check_count;
  logic [31:0] corner [17] = '{32'h0, 32'h000FFFFF, 32'h00301234, 32'h0030FFFF, 32'h00310000,
    32'h00400000, 32'h004FFFFF, 32'h00500000, 32'h10000000, 32'h6FFFFFFF, 32'h70000010,
    32'h80000000, 32'hF0000000, 32'h00107FFF, 32'h00108000, 32'h00200000, 32'h0020FFFF};

  brd_master_model master_model (.core_clk_in(clk), .go_in(go), .master_in(mst), .addr_in(adr),
    .req_out(req));
  brd_decoder dut (.core_clk_in(clk), .rst_n_in(rst_n), .req_in(req), .boot_select_pin_in(pin),
    .master_remap_bit_in(rbits), .tcm_wait_state_bit_in(wbit), .part_in(part), .route_out(route),
    .tcm_wait_out(twait), .boot_from_rom_out(brom), .smc_byte_select_out(sbs),
    .smc_bus16_out(s16), .smc_cs_qualified_out(scs));

  always #20 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic brd_tgt_e exp_tgt(input logic [3:0] m, input logic [31:0] a,
    input logic [11:0] rb, input logic bp, input logic [1:0] p);
    logic rm;
    logic [19:0] lo;
    rm = (m < 4'h2) ? rb[m] : 1'b0;
    lo = a[19:0];
    case (a[31:28])
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: return BRD_TGT_EXT;
      4'h7: return BRD_TGT_DRAM;
      4'hF: return BRD_TGT_PERIPH;
      4'h0: ;
      default: return BRD_TGT_ABORT;
    endcase
    case (a[27:20])
      8'h00: return rm ? ((m < 4'h2 && p == 2'b00 && lo < 20'h10000) ? BRD_TGT_SRAM : BRD_TGT_ABORT)
                       : (bp ? BRD_TGT_ROM : BRD_TGT_EXT);
      8'h01: return (p == 2'b10 && lo < 20'h08000) ? BRD_TGT_INSTR_COUPLED_MEMORY : BRD_TGT_ABORT;
      8'h02: return ((p == 2'b01 && lo < 20'h10000) || (p == 2'b10 && lo < 20'h08000))
                    ? BRD_TGT_DATA_COUPLED_MEMORY : BRD_TGT_ABORT;
      8'h03: return (p == 2'b00 && lo < 20'h10000) ? BRD_TGT_SRAM : BRD_TGT_ABORT;
      8'h04: return BRD_TGT_ROM;
      default: return BRD_TGT_ABORT;
    endcase
  endfunction : exp_tgt

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One request per cycle; the route of the previous one is checked here
  task automatic step(input logic v, input logic [3:0] m, input logic [31:0] a);
    brd_tgt_e t;
    logic [1:0] p;
    seed = lfsr(seed);
    p = (seed[3:2] == 2'b11) ? 2'b00 : seed[3:2];
    t = exp_tgt(m, a, {10'h000, seed[1:0]}, pin, p);
    @(posedge clk);
    go <= v;
    mst <= m;
    adr <= a;
    rbits <= {10'h000, seed[1:0]};
    wbit <= seed[4];
    part <= brd_part_e'(p);
    #1;
    check("valid", 32'(pv), 32'(route.valid));
    check("tcm_wait", 32'(pv && pw && (pt == BRD_TGT_INSTR_COUPLED_MEMORY || pt == BRD_TGT_DATA_COUPLED_MEMORY)), 32'(twait));
    if (pv) begin
      check("target", 32'(pt), 32'(route.target));
      check("abort", 32'(pt == BRD_TGT_ABORT), 32'(route.abort));
      check("dram_select", 32'(pt == BRD_TGT_DRAM), 32'(route.dram_select));
      check("master", 32'(pm), 32'(route.master));
      check("ext_select", (pt != BRD_TGT_EXT) ? 32'h0 : (pa[31:28] == 4'h0) ? 32'h1 :
        32'h1 << (pa[31:28] - 4'h1), 32'(route.ext_select));
      if (pt == BRD_TGT_SRAM || pt == BRD_TGT_INSTR_COUPLED_MEMORY || pt == BRD_TGT_DATA_COUPLED_MEMORY) begin
        check("local_offset", {16'h0000, pa[15:0]}, route.offset);
      end
      if (pa[31:28] != 4'h0 && pt != BRD_TGT_ABORT) begin
        check("offset", pa, route.offset);
      end
    end
    pv = v;
    pt = t;
    pa = a;
    pm = m;
    pw = seed[4];
  endtask : step

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  initial begin
    #(40 * 5000);
    err_total++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {go, pin, wbit, pv, pw, mst, pm, adr, pa, rbits} = '0;
    part = BRD_PART_ALL_SRAM;
    pt = BRD_TGT_ABORT;
    err_total = 0;
    check_count = 0;
    seed = 32'h2C;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      pin <= (k == 0);
      repeat (20) @(posedge clk);
      #1;
      check("reset_valid", 32'h0, 32'(route.valid));
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check("boot_rom", 32'(pin), 32'(brom));
      check("smc_mode", {29'h0, {3{~pin}}}, {29'h0, sbs, s16, scs});
      pv = 1'b0;
      foreach (corner[i]) step(1'b1, 4'(i % 3), corner[i]);
      repeat (400) begin
        seed = lfsr(seed);
        step(seed[5] | seed[6], 4'(seed[11:8] % 4'hC),
          seed[27] ? {4'h0, 5'h00, seed[26:24], 3'h0, seed[16:0]} : seed);
      end
      step(1'b0, 4'h0, 32'h0);
      $display("test boot pin %0d done", pin);
    end
    conclude();
  end
endmodule : brd_decoder_tb

// ==== test/brd_master_model.sv ====
// Bus master model: presents at most one request a cycle to the decoder.
// Assumes the bench drives go, master and address just after the rising edge.
`timescale 1ns/10ps
module brd_master_model (
  input wire logic core_clk_in,
  input wire logic go_in,
  input wire logic [3:0] master_in,
  input wire logic [31:0] addr_in,
  output brd_pkg::brd_req_s req_out
);
  import brd_pkg::*;
  logic [31:0] last_reg = 32'h0;
  // Idle bus shows the inverse of the last address, never a stale copy
  assign req_out = go_in ? '{valid: 1'b1, master: master_in, addr: addr_in}
                         : '{valid: 1'b0, master: ~master_in, addr: ~last_reg};
  always_ff @(posedge core_clk_in) begin
    if (go_in) begin
      last_reg <= addr_in;
    end
  end
endmodule : brd_master_model
